// *** dv/lss_checker.sv ***
// assertions on the sink front end
// assumes pins paced as the hand-over asks
module lss_checker (
  // watched ports
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_latch_strobe,
  input wire logic i_blank_n,
  input wire logic i_shift_clk,
  input wire logic o_serial_out,
  input wire logic [15:0] o_sink_outputs
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // open latch settled: sinks move one stage
  sink_walk_a: assert property ((i_latch_strobe && !i_blank_n)[*8] ##0
    $changed(o_sink_outputs) |-> o_sink_outputs[15:1] ==
    $past(o_sink_outputs[14:0])) else $error("walk");
  latch_hold_a: assert property ((!i_latch_strobe && !i_blank_n)[*8] |=>
    $stable(o_sink_outputs)) else $error("hold");
  sink_on_a: assert property ($rose(|o_sink_outputs) |->
    !$past(i_blank_n, 3)) else $error("on");
  // blanking held long enough: every sink off
  blank_off_a: assert property (i_blank_n[*6] |->
    o_sink_outputs == 16'h0000) else $error("blank");
  // no shift clock activity: chain output holds
  sout_stable_a: assert property ((!i_shift_clk)[*8] |=>
    $stable(o_serial_out)) else $error("sout");
  // open latch, idle shift clock: sinks settle and stay
  shift_idle_a: assert property ((!i_shift_clk && !i_blank_n &&
    i_latch_strobe)[*8] |=> $stable(o_sink_outputs)) else $error("idle");
  cover property ($fell(i_blank_n));
  cover property ($fell(i_latch_strobe));
  cover property ($rose(i_latch_strobe));
endmodule : lss_checker
bind lss_shift_latch lss_checker u_chk (.*);

// *** dv/lss_partner.sv ***
// controller model on the serial pins
// assumes calls start on a falling edge
module lss_partner (
  // serial pins
  output logic o_shift_clk,
  output logic o_serial_in
);
  timeunit 1ns / 1ps;
  initial {o_shift_clk, o_serial_in} = 2'h0;
  // msb first; setup 4 cycles, high 3
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      o_serial_in = w[i];
      #32 o_shift_clk = 1'h1;
      #24 o_shift_clk = 1'h0;
      o_serial_in = ~w[i]; // hold over: garble
      #8;
    end
  endtask : send
endmodule : lss_partner

// *** dv/tb_lss_shift_latch.sv ***
// bench: sinks and chain pin judged
// assumes 125 MHz clock, pins moved on falling edges
module tb_lss_shift_latch;
  timeunit 1ns / 1ps;
  logic clk = 0, rst_n = 0, stb = 0, blk_n = 1, sck, din, dout, rdy;
  logic [15:0] sinks;
  int failures = 0, compares = 0;
  always #4 clk = ~clk;
  lss_partner u_ctl (.o_shift_clk(sck), .o_serial_in(din));
  lss_shift_latch uut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'h1),
    .i_shift_clk(sck), .i_serial_in(din), .i_latch_strobe(stb),
    .i_blank_n(blk_n), .o_sink_outputs(sinks), .o_serial_out(dout),
    .o_bit_ready(rdy));
  task automatic chk(input int n, input logic [16:0] exp);
    repeat (n) @(negedge clk);
    compares++;
    if ({rdy, dout, sinks} !== {1'b1, exp}) begin
      failures++;
      $display("[ERR] %0t %h %h", $time, {rdy, dout, sinks}, {1'b1, exp});
    end
  endtask : chk
  task automatic t_open();
    stb = 1'h1;
    blk_n = 1'h0;
    u_ctl.send(16'hA5C3);
    chk(10, 17'h1A5C3);
  endtask : t_open
  task automatic t_hold();
    stb = 1'h0;
    u_ctl.send(16'h0F0E);
    chk(10, 17'h0A5C3);
    stb = 1'h1;
    chk(10, 17'h00F0E);
    blk_n = 1'h1;
    chk(8, 17'h00000);
    blk_n = 1'h0;
    chk(8, 17'h00F0E);
  endtask : t_hold
  // mid-run reset clears shift, latch and chain output
  task automatic t_reset();
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    chk(8, 17'h00000);
  endtask : t_reset
  task automatic print_verdict();
    $display("%0d compares %0d failures", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // reset 12 cycles, then scenarios
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    t_open();
    t_hold();
    t_reset();
    print_verdict();
  end
  initial begin // hang guard
    #20000;
    failures++;
    print_verdict();
  end
endmodule : tb_lss_shift_latch

// *** rtl/lss_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
// assumes one clock, active-low async reset, clock enable
module lss_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } lss_fifo_s;
  lss_fifo_s st;
  lss_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // handshakes; full and empty come from the count
  assign o_in_ready = (st.count < (AW+1)'(DEPTH)); // full at DEPTH entries
  assign o_out_valid = (st.count != '0);
  assign o_out_data = mem[st.rd];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  // storage has no reset; only valid entries are ever read
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && push) begin
      mem[st.wr] <= i_in_data;
    end
  end
endmodule : lss_fifo

// *** rtl/lss_pkg.sv ***
// constants for the sixteen-channel serial-in, parallel-out sink front end
// assumes one system clock; pin inputs are synchronised inside the top
// What this block does
// - shift serial input on each shift clock rise
// - latch transparent while latch strobe high
// - falling strobe freezes latch during further shifting
// - blanking low: sinks follow latched bits
// - blanking high: all sinks off, state kept
// - last shift stage drives serial output
// - sixteen sink channels, one latch bit each
package lss_pkg;
  localparam int unsigned CHANNELS = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [15:0] RESET_SHIFT = 16'h0000;
  localparam logic [15:0] RESET_LATCH = 16'h0000;
  localparam logic [15:0] SINKS_OFF = 16'h0000;
  localparam logic [2:0] RESET_SYNC = 3'h0;
  localparam logic [2:0] RESET_BLANK_SYNC = 3'h7;
endpackage : lss_pkg

// *** rtl/lss_shift_latch.sv ***
// serial-in, parallel-out shift register, output latch and blanking
// assumes shift clock, serial in, strobe and blank arrive as async pins
module lss_shift_latch #(
  parameter int unsigned CHANNELS = lss_pkg::CHANNELS,
  parameter int unsigned FIFO_DEPTH = lss_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // serial pins
  input wire logic i_shift_clk,
  input wire logic i_serial_in,
  input wire logic i_latch_strobe,
  input wire logic i_blank_n,
  // outputs
  output logic [CHANNELS-1:0] o_sink_outputs,
  output logic o_serial_out,
  output logic o_bit_ready
);
  typedef struct packed {
    logic [2:0] clk_sync;
    logic [2:0] din_sync;
    logic [2:0] le_sync;
    logic [2:0] oe_sync;
    logic clk_state;
    logic le_state;
    logic oe_n_state;
    logic [CHANNELS-1:0] shift;
    logic [CHANNELS-1:0] latch;
    logic [CHANNELS-1:0] sinks;
    logic sout;
    logic ready;
  } lss_core_s;
  lss_core_s st;
  lss_core_s next_st;
  logic rise;
  logic bit_valid;
  logic bit_data;
  logic bit_take;
  logic fifo_ready;

  // a shift-clock rise is queued with the data bit seen alongside it
  assign rise = (st.clk_sync[2] == st.clk_sync[1]) &&
                st.clk_sync[2] && !st.clk_state;
  assign bit_take = bit_valid;

  lss_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_in_valid(rise),
    .i_in_data(st.din_sync[2]),
    .o_in_ready(fifo_ready),
    .o_out_valid(bit_valid),
    .o_out_data(bit_data),
    .i_out_ready(bit_take)
  );

  // synchronisers: stage 0 feeds only stage 1; 1 and 2 must agree, except serial in, taken from stage 2 directly
  always_comb begin
    next_st = st;
    next_st.clk_sync = {st.clk_sync[1:0], i_shift_clk};
    next_st.din_sync = {st.din_sync[1:0], i_serial_in};
    next_st.le_sync = {st.le_sync[1:0], i_latch_strobe};
    next_st.oe_sync = {st.oe_sync[1:0], i_blank_n};
    // ready lags the fifo by a cycle so the pin comes from a flop
    next_st.ready = fifo_ready;
    if (st.clk_sync[2] == st.clk_sync[1]) begin
      next_st.clk_state = st.clk_sync[2];
    end
    if (st.le_sync[2] == st.le_sync[1]) begin
      next_st.le_state = st.le_sync[2];
    end
    if (st.oe_sync[2] == st.oe_sync[1]) begin
      next_st.oe_n_state = st.oe_sync[2];
    end
    // newest bit enters channel zero, older bits move up
    if (bit_take) begin
      next_st.shift = {st.shift[CHANNELS-2:0], bit_data};
      next_st.sout = st.shift[CHANNELS-2];
    end
    // strobe high passes the shift register, low holds the latch
    if (st.le_state) begin
      next_st.latch = next_st.shift;
    end else begin
      next_st.latch = st.latch;
    end
    // blanking only gates the pins; latch and shift untouched
    if (st.oe_n_state) begin
      next_st.sinks = lss_pkg::SINKS_OFF;
    end else begin
      next_st.sinks = st.latch;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st.clk_sync <= lss_pkg::RESET_SYNC;
      st.din_sync <= lss_pkg::RESET_SYNC;
      st.le_sync <= lss_pkg::RESET_SYNC;
      st.oe_sync <= lss_pkg::RESET_BLANK_SYNC;
      st.clk_state <= 1'b0;
      st.le_state <= 1'b0;
      st.oe_n_state <= 1'b1;
      st.shift <= lss_pkg::RESET_SHIFT;
      st.latch <= lss_pkg::RESET_LATCH;
      st.sinks <= lss_pkg::SINKS_OFF;
      st.sout <= 1'b0;
      st.ready <= 1'b1;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  // all outputs straight from flops
  assign o_sink_outputs = st.sinks;
  assign o_serial_out = st.sout;
  assign o_bit_ready = st.ready;
endmodule : lss_shift_latch
